//--- mdio_mmd_pkg.sv
// Constants, state codes and carrier types for the serial management port.
package mdio_mmd_pkg;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam logic [4:0]  REG_ACCESS_CONTROL = 5'h0d;
  localparam logic [4:0]  REG_ADDR_OR_DATA   = 5'h0e;
  localparam logic [15:0] EXT_BLOCKED_LO     = 16'h000d;
  localparam logic [15:0] EXT_BLOCKED_HI     = 16'h000e;
  localparam logic [15:0] ACCESS_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] POINTER_RESET      = 16'h0000;
  localparam logic [15:0] READ_ZERO          = 16'h0000;
  localparam logic [15:0] POINTER_STEP       = 16'h0001;
  localparam int          FN_HI              = 15;
  localparam int          FN_LO              = 14;
  localparam int          DEV_HI             = 4;
  localparam int          DEV_LO             = 0;
  localparam logic [4:0]  DEVICE_GENERAL     = 5'h1f;

  // ==========================================================================
  // Access functions of the access-control register
  // ==========================================================================
  localparam logic [1:0] FN_ADDRESS     = 2'h0;
  localparam logic [1:0] FN_DATA        = 2'h1;
  localparam logic [1:0] FN_DATA_INC_RW = 2'h2;
  localparam logic [1:0] FN_DATA_INC_WR = 2'h3;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [3:0] HEADER_LAST = 4'hb;
  localparam logic [3:0] TURN_LAST   = 4'h1;
  localparam logic [3:0] DATA_LAST   = 4'hf;
  localparam int         OP_HI       = 11;
  localparam int         OP_LO       = 10;
  localparam int         PHY_HI      = 9;
  localparam int         PHY_LO      = 5;
  localparam int         REG_HI      = 4;
  localparam int         REG_LO      = 0;
  localparam int         NARROW_BIT  = 4;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int         CLK_SYS_MHZ  = 10;
  localparam int         MDC_MAX_MHZ  = 25;
  localparam int         SYNC_STAGES  = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_START  = 5'b00010,
    ST_HEADER = 5'b00100,
    ST_TURN   = 5'b01000,
    ST_DATA   = 5'b10000
  } frame_state_t;

  // Request toward the register contents that live outside this block.
  typedef struct packed {
    logic        extended;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } usr_req_t;

endpackage : mdio_mmd_pkg

//--- pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clk_sys domain.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end

endmodule : pin_sync

//--- mdio_mmd_slave.sv
// Serial management port slave with indirect extended-space access path.
//
// Contract
// RL1 - Station clocks at most 25 MHz, may stop; slave needs no free clock. Here mdc is sampled by the 10 MHz clk_sys, so it must run far slower.
// RL2 - Receiver samples the data line on the rising clock edge.
// RL3 - Bus address caught from straps after reset; 4-bit, or 5-bit when wide.
// RL4 - Station leaves the bus idle for a clock after reset.
// RL5 - Register field picks one of 32 registers of 16 bits directly.
// RL6 - Each frame starts with a zero then a one after idle.
// RL7 - Frame: start, opcode 10 read or 01 write, addresses, turnaround, 16 data.
// RL8 - Nobody drives the first turnaround bit of a read.
// RL9 - Addressed slave drives zero in second turnaround bit, then 16 data bits.
// RL10 - On writes the station drives turnaround one-zero and data.
// RL11 - Indirect access to the access-control or address/data register is ignored.
// RL12 - Device select bits 4:0 must be 11111, else indirect accesses ignored.
// RL13 - Function bits 15:14: address, data, increment both, increment on writes.
// RL14 - Function address makes the address/data register reach the pointer.
// RL15 - Repeated writes with function address keep overwriting the pointer.
// RL16 - Function data reaches the pointed register, pointer kept.
// RL17 - Function increment-both bumps pointer after reads and writes.
// RL18 - Function increment-on-writes bumps pointer after writes only.
// RL19 - Station sets the pointer before extended accesses.
// RL20 - Station writes 001F, address, 401F, then data through address/data.
// RL21 - Station may skip pointer setup when pointer already right.
// RL22 - Data line driven only in second turnaround and data of own reads.
`timescale 1ns/100ps
module mdio_mmd_slave
  import mdio_mmd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  input  wire logic [4:0] bus_address_straps,
  input  wire logic       wide_address_strap,
  output logic [4:0]      bus_address,
  output logic            address_valid,
  output usr_req_t        usr_req,
  input  wire logic [15:0] usr_rdata
);

  // ==========================================================================
  // Pin synchronisation and clock edge detection
  // ==========================================================================
  logic [7:0]   pins_s;
  logic         mdc_s;
  logic         mdio_s;
  logic         wide_s;
  logic [4:0]   straps_s;
  logic         mdc_prev_q;
  logic         mdc_rise;
  logic         mdc_fall;

  pin_sync #(.WIDTH(8)) u_pin_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  ({mdc, mdio_i, wide_address_strap, bus_address_straps}),
    .pin_out (pins_s)
  );

  assign mdc_s    = pins_s[7];
  assign mdio_s   = pins_s[6];
  assign wide_s   = pins_s[5];
  assign straps_s = pins_s[4:0];

  // Edges are found by sampling, so a stopped clock simply produces none.
  assign mdc_rise = mdc_s & ~mdc_prev_q;   // see RL1 see RL2
  assign mdc_fall = ~mdc_s & mdc_prev_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) mdc_prev_q <= 1'b0;
    else         mdc_prev_q <= mdc_s;
  end

  // ==========================================================================
  // Strap capture after reset release
  // ==========================================================================
  logic [1:0] settle_q;
  logic       wide_q;
  logic       strap_take;

  // Reset clears the synchroniser, so the straps reach straps_s only after two edges.
  assign strap_take = (settle_q == STRAP_SETTLE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      settle_q      <= 2'h0;
      bus_address   <= 5'h00;
      wide_q        <= 1'b0;
      address_valid <= 1'b0;
    end else if (!address_valid) begin
      settle_q <= settle_q + 2'h1;
      if (strap_take) begin
        bus_address   <= straps_s;   // see RL3
        wide_q        <= wide_s;
        address_valid <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Frame decode
  // ==========================================================================
  frame_state_t state_q;
  logic [3:0]   cnt_q;
  logic [11:0]  hdr_q;
  logic [15:0]  data_q;
  logic         hit_q;
  logic         rd_q;
  logic [11:0]  hdr_full;
  logic [15:0]  data_full;
  logic         hdr_done;
  logic         data_done;
  logic         op_ok;
  logic         phy_match;
  logic         hdr_is_rd;

  assign hdr_full  = {hdr_q[10:0], mdio_s};
  assign data_full = {data_q[14:0], mdio_s};
  assign hdr_done  = mdc_rise && (state_q == ST_HEADER) && (cnt_q == HEADER_LAST);
  assign data_done = mdc_rise && (state_q == ST_DATA) && (cnt_q == DATA_LAST);
  assign hdr_is_rd = (hdr_full[OP_HI:OP_LO] == OP_READ);
  assign op_ok     = hdr_is_rd || (hdr_full[OP_HI:OP_LO] == OP_WRITE);   // see RL7
  assign phy_match = address_valid &&
                     (wide_q ? (hdr_full[PHY_HI:PHY_LO] == bus_address)
                             : (hdr_full[PHY_HI:PHY_LO] ==
                                {1'b0, bus_address[NARROW_BIT-1:0]}));   // see RL3

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      hdr_q   <= 12'h000;
      data_q  <= 16'h0000;
      hit_q   <= 1'b0;
      rd_q    <= 1'b0;
    end else if (mdc_rise) begin   // see RL2
      case (state_q)
        ST_IDLE: begin
          if (!mdio_s) state_q <= ST_START;   // see RL6
        end
        ST_START: begin
          state_q <= mdio_s ? ST_HEADER : ST_IDLE;   // see RL6
          cnt_q   <= 4'h0;
        end
        ST_HEADER: begin
          hdr_q <= hdr_full;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == HEADER_LAST) begin
            state_q <= op_ok ? ST_TURN : ST_IDLE;
            cnt_q   <= 4'h0;
            hit_q   <= phy_match;
            rd_q    <= hdr_is_rd;
          end
        end
        ST_TURN: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == TURN_LAST) begin
            state_q <= ST_DATA;
            cnt_q   <= 4'h0;
          end
        end
        ST_DATA: begin
          data_q <= data_full;
          cnt_q  <= cnt_q + 4'h1;
          if (cnt_q == DATA_LAST) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= 4'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Access-control register, pointer and access decode
  // ==========================================================================
  logic [15:0] access_ctrl_q;
  logic [15:0] pointer_q;
  logic [4:0]  rd_reg;
  logic [4:0]  wr_reg;
  logic [1:0]  func;
  logic        dev_ok;
  logic        ptr_blocked;
  logic        rd_go;
  logic        wr_go;
  logic        rd_ctrl;
  logic        rd_indir;
  logic        wr_ctrl;
  logic        wr_indir;
  logic        rd_ext;
  logic        wr_ext;
  logic        rd_direct;
  logic        wr_direct;
  logic        wr_pointer;
  logic        inc_on_rd;
  logic        inc_on_wr;

  assign func        = access_ctrl_q[FN_HI:FN_LO];                          // see RL13
  assign dev_ok      = (access_ctrl_q[DEV_HI:DEV_LO] == DEVICE_GENERAL);    // see RL12
  assign ptr_blocked = (pointer_q == EXT_BLOCKED_LO) ||
                       (pointer_q == EXT_BLOCKED_HI);                       // see RL11
  assign rd_reg      = hdr_full[REG_HI:REG_LO];                             // see RL5
  assign wr_reg      = hdr_q[REG_HI:REG_LO];
  assign rd_go       = hdr_done && op_ok && phy_match && hdr_is_rd;
  assign wr_go       = data_done && hit_q && !rd_q;
  assign rd_ctrl     = rd_go && (rd_reg == REG_ACCESS_CONTROL);
  assign rd_indir    = rd_go && (rd_reg == REG_ADDR_OR_DATA);
  assign wr_ctrl     = wr_go && (wr_reg == REG_ACCESS_CONTROL);
  assign wr_indir    = wr_go && (wr_reg == REG_ADDR_OR_DATA);
  assign rd_direct   = rd_go && !rd_ctrl && !rd_indir;                      // see RL5
  assign wr_direct   = wr_go && !wr_ctrl && !wr_indir;
  assign rd_ext      = rd_indir && dev_ok && (func != FN_ADDRESS) && !ptr_blocked;
  assign wr_ext      = wr_indir && dev_ok && (func != FN_ADDRESS) && !ptr_blocked;
  assign wr_pointer  = wr_indir && dev_ok && (func == FN_ADDRESS);          // see RL15
  assign inc_on_rd   = rd_ext && (func == FN_DATA_INC_RW);                  // see RL17 see RL18
  assign inc_on_wr   = wr_ext && ((func == FN_DATA_INC_RW) ||
                                  (func == FN_DATA_INC_WR));                // see RL17 see RL18

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      access_ctrl_q <= ACCESS_CTRL_RESET;
      pointer_q     <= POINTER_RESET;
    end else begin
      if (wr_ctrl) access_ctrl_q <= data_full;
      if (wr_pointer) begin
        pointer_q <= data_full;   // see RL14
      end else if (inc_on_rd || inc_on_wr) begin
        pointer_q <= pointer_q + POINTER_STEP;   // see RL17 see RL18
      end
    end
  end

  // ==========================================================================
  // Requests toward the register contents and read data capture
  // ==========================================================================
  logic        fetch_q;
  logic [15:0] rdata_q;
  logic [15:0] local_rdata;

  // Reads that the slave answers itself; ignored indirect reads return zero.
  assign local_rdata = rd_ctrl                               ? access_ctrl_q :
                       (rd_indir && dev_ok && func == FN_ADDRESS) ? pointer_q :   // see RL14
                       READ_ZERO;                                                 // see RL11 see RL12

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      usr_req <= '0;
      fetch_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      usr_req.rd <= rd_ext || rd_direct;
      usr_req.wr <= wr_ext || wr_direct;
      fetch_q    <= rd_ext || rd_direct;
      if (rd_ext || wr_ext) begin
        usr_req.extended <= 1'b1;
        usr_req.addr     <= pointer_q;   // see RL16
      end else if (rd_direct || wr_direct) begin
        usr_req.extended <= 1'b0;
        usr_req.addr     <= {11'h000, rd_direct ? rd_reg : wr_reg};
      end
      if (wr_ext || wr_direct) usr_req.wdata <= data_full;
      if (fetch_q) begin
        rdata_q <= usr_rdata;
      end else if (rd_go) begin
        rdata_q <= local_rdata;
      end
    end
  end

  // ==========================================================================
  // Data line drive
  // ==========================================================================
  logic       drive_turn;
  logic       drive_data;
  logic [3:0] bit_sel;

  assign drive_turn = (state_q == ST_TURN) && (cnt_q == TURN_LAST) && hit_q && rd_q;
  assign drive_data = (state_q == ST_DATA) && hit_q && rd_q;
  assign bit_sel    = DATA_LAST - cnt_q;

  // Output changes on the falling clock edge so the station samples it
  // stable on the next rising edge. The last rising edge of a frame
  // releases the line at once, in case the clock then stops high.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mdio_oe <= 1'b0;
      mdio_o  <= 1'b0;
    end else if (data_done || state_q == ST_IDLE) begin
      mdio_oe <= 1'b0;   // see RL22
      mdio_o  <= 1'b0;
    end else if (mdc_fall) begin
      mdio_oe <= drive_turn || drive_data;   // see RL8 see RL22
      mdio_o  <= drive_data ? rdata_q[bit_sel] : 1'b0;   // see RL9
    end
  end

endmodule : mdio_mmd_slave

//--- mdio_mmd_slave_asserts.sv
// Concurrent checks on the ports of the management slave.
`timescale 1ns/100ps
module mdio_mmd_slave_asserts
  import mdio_mmd_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        mdc,
  input wire logic        mdio_i,
  input wire logic        mdio_o,
  input wire logic        mdio_oe,
  input wire logic [4:0]  bus_address_straps,
  input wire logic        wide_address_strap,
  input wire logic [4:0]  bus_address,
  input wire logic        address_valid,
  input wire usr_req_t    usr_req,
  input wire logic [15:0] usr_rdata
);
  // Read drive spans the second turnaround bit and 16 data bits of an 800 ns link clock.
  localparam int OE_MIN = 129;
  localparam int OE_MAX = 135;
  logic [7:0] oe_cnt_q;
  logic [3:0] low_cnt_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oe_cnt_q  <= 8'h00;
      low_cnt_q <= 4'h0;
    end else begin
      oe_cnt_q  <= mdio_oe ? oe_cnt_q + 8'h01 : 8'h00;
      low_cnt_q <= (mdc || low_cnt_q == 4'hf) ? {4{~mdc}} & low_cnt_q : low_cnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_ta_zero;
    (mdio_oe && !mdio_o) [*7];
  endsequence
  sequence s_pulse_end(logic x);
    ##1 !x;
  endsequence
  a_ta_zero: assert property ($rose(mdio_oe) |-> !$past(mdc) ##0 s_ta_zero)
    else $error("turnaround drive is not a low bit");
  a_drive_len: assert property ($fell(mdio_oe) |-> oe_cnt_q >= OE_MIN && oe_cnt_q <= OE_MAX)
    else $error("read drive has the wrong length");
  a_change_low: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_o)
    |-> !$past(mdc) && !$past(mdc, 2)) else $error("data changed while clock high");
  a_idle_quiet: assert property (low_cnt_q > 4'h6 |-> !mdio_oe)
    else $error("data line driven while clock stands");
  a_valid_rise: assert property ($rose(resetn) |-> ##[1:4] address_valid)
    else $error("address not captured after reset");
  a_addr_kept: assert property (address_valid |=> address_valid && $stable(bus_address))
    else $error("captured address moved");
  a_addr_strap: assert property ($rose(address_valid)
    |-> bus_address[3:0] == bus_address_straps[3:0]) else $error("address differs from straps");
  a_rd_pulse: assert property (usr_req.rd |-> !usr_req.wr ##0 s_pulse_end(usr_req.rd))
    else $error("read request is not a single pulse");
  a_wr_pulse: assert property (usr_req.wr |-> $past(mdc, 2) && !mdio_oe
    ##0 s_pulse_end(usr_req.wr)) else $error("write request out of place");
  a_ext_block: assert property ((usr_req.wr || usr_req.rd) && usr_req.extended
    |-> usr_req.addr != EXT_BLOCKED_LO && usr_req.addr != EXT_BLOCKED_HI)
    else $error("blocked extended address reached");
  a_direct_reg: assert property ((usr_req.wr || usr_req.rd) && !usr_req.extended
    |-> usr_req.addr[4:0] != REG_ACCESS_CONTROL && usr_req.addr[4:0] != REG_ADDR_OR_DATA)
    else $error("local register passed outside");
endmodule : mdio_mmd_slave_asserts
bind mdio_mmd_slave mdio_mmd_slave_asserts u_asserts (.clk_sys(clk_sys), .resetn(resetn),
  .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .bus_address_straps(bus_address_straps), .wide_address_strap(wide_address_strap),
  .bus_address(bus_address), .address_valid(address_valid), .usr_req(usr_req),
  .usr_rdata(usr_rdata));

//--- mdio_station.sv
// Station model that clocks management frames onto the shared data line.
`timescale 1ns/100ps
module mdio_station
  import mdio_mmd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      sta_oe,
  output logic      sta_o
);
  initial begin
    mdc    = 1'b0;
    sta_oe = 1'b0;
    sta_o  = 1'b0;
  end
  // One bit time: data is set while the clock is low and sampled at the rise.
  task automatic cyc(input logic en, input logic b, output logic s);
    sta_oe = en;
    sta_o  = b;
    repeat (4) @(posedge clk_sys);
    #10 mdc = 1'b1;
    s = mdio_wire;
    repeat (4) @(posedge clk_sys);
    #10 mdc = 1'b0;
  endtask : cyc
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [17:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, phy, rg};
    rd  = 18'h0_0000;
    @(posedge clk_sys);
    #10;
    for (int i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
    if (op == OP_WRITE) begin
      cyc(1'b1, 1'b1, s);
      cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) cyc(1'b1, wd[i], s);
    end else if (op == OP_READ) begin
      for (int i = 17; i >= 0; i--) begin
        cyc(1'b0, 1'b0, s);
        rd[i] = s;
      end
    end
    sta_oe = 1'b0;
    // The clock stands still between frames.
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : mdio_station

//--- tb.sv
// Self-checking bench for the management slave with a reference model.
`timescale 1ns/100ps
module tb;
  import mdio_mmd_pkg::*;
  logic        clk_sys, mdc, sta_oe, sta_o, mdio_o, mdio_oe, address_valid;
  logic        resetn = 1'b0, wide = 1'b1;
  logic [4:0]  straps = 5'h00, bus_address;
  logic [15:0] usr_rdata = 16'h0000, m_ctrl, m_ptr;
  logic [32:0] w_exp;
  usr_req_t    usr_req;
  wire logic   mdio_wire;
  logic [15:0] ref_mem [logic [16:0]];
  logic [15:0] dut_mem [logic [16:0]];
  logic [32:0] exp_wr [$];
  int          err_total, n_compared, cycles;
  wire logic [16:0] u_key = {usr_req.extended, usr_req.addr};
  assign mdio_wire = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);
  mdio_mmd_slave u_dut (.clk_sys(clk_sys), .resetn(resetn), .mdc(mdc), .mdio_i(mdio_wire),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .bus_address_straps(straps),
    .wide_address_strap(wide), .bus_address(bus_address), .address_valid(address_valid),
    .usr_req(usr_req), .usr_rdata(usr_rdata));
  mdio_station u_sta (.clk_sys(clk_sys), .mdio_wire(mdio_wire), .mdc(mdc), .sta_oe(sta_oe),
    .sta_o(sta_o));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] look(ref logic [15:0] m [logic [16:0]], input logic [16:0] k);
    return m.exists(k) ? m[k] : k[15:0] ^ 16'ha5c3;
  endfunction : look
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      conclude();
    end
  end
  // Register contents beyond the slave: stores writes and answers a read within the cycle
  // of its request, since the slave takes the read data at the edge that ends the pulse.
  always @(posedge clk_sys) begin
    if (usr_req.wr === 1'b1) begin
      dut_mem[u_key] = usr_req.wdata;
      w_exp = exp_wr.size() > 0 ? exp_wr.pop_front() : 33'bx;
      check({u_key, usr_req.wdata}, w_exp);
    end
    #10 usr_rdata = (usr_req.rd === 1'b1) ? look(dut_mem, u_key) : ~usr_rdata;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] rg, input logic [15:0] wd,
                       input logic hit);
    logic [4:0]  phy;
    logic [16:0] k;
    logic [15:0] exp;
    logic [17:0] got;
    logic [1:0]  fn;
    logic        rd, use_usr;
    phy = (wide ? straps : {1'b0, straps[3:0]}) ^ (hit ? 5'h00 : 5'h10);
    rd = (op == OP_READ);
    fn = m_ctrl[FN_HI:FN_LO];
    exp = READ_ZERO;
    use_usr = 1'b0;
    k = {12'h000, rg};
    if (hit && (rd || op == OP_WRITE)) begin
      if (rg == REG_ACCESS_CONTROL) begin
        exp = m_ctrl;
        if (!rd) m_ctrl = wd;
      end else if (rg != REG_ADDR_OR_DATA) begin
        use_usr = 1'b1;
      end else if (m_ctrl[DEV_HI:DEV_LO] != DEVICE_GENERAL) begin
        exp = READ_ZERO;
      end else if (fn == FN_ADDRESS) begin
        exp = m_ptr;
        if (!rd) m_ptr = wd;
      end else if (m_ptr != EXT_BLOCKED_LO && m_ptr != EXT_BLOCKED_HI) begin
        k = {1'b1, m_ptr};
        use_usr = 1'b1;
        if (fn == FN_DATA_INC_RW || (fn == FN_DATA_INC_WR && !rd)) m_ptr++;
      end
    end
    if (use_usr && rd) exp = look(ref_mem, k);
    if (use_usr && !rd) begin
      ref_mem[k] = wd;
      exp_wr.push_back({k, wd});
    end
    u_sta.xfer(op, phy, rg, wd, got);
    if (rd) check(33'(got), 33'(hit ? {2'b10, exp} : 18'h3_ffff));
  endtask : frame
  task automatic ctl(input logic [15:0] d);
    frame(OP_WRITE, REG_ACCESS_CONTROL, d, 1'b1);
  endtask : ctl
  task automatic ad(input logic [1:0] op, input logic [15:0] d);
    frame(op, REG_ADDR_OR_DATA, d, 1'b1);
  endtask : ad
  task automatic rand_frames(input int n);
    logic [15:0] wd;
    logic [4:0]  rg;
    for (int i = 0; i < n; i++) begin
      wd = 16'($urandom);
      rg = ($urandom % 3 == 0) ? 5'($urandom) : REG_ACCESS_CONTROL + 5'($urandom % 2);
      if (rg == REG_ACCESS_CONTROL) wd = {wd[15:14], 9'h000, wd[5] ? 5'h1f : wd[4:0]};
      frame(wd[6] ? OP_READ : OP_WRITE, rg, wd, $urandom % 8 != 0);
    end
  endtask : rand_frames
  task automatic do_reset(input logic w);
    #10 resetn = 1'b0;
    wide   = w;
    straps = 5'($urandom);
    m_ctrl = ACCESS_CTRL_RESET;
    m_ptr  = POINTER_RESET;
    repeat (12) @(posedge clk_sys);
    #10 resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #10 check(33'({address_valid, bus_address[3:0]}), 33'({1'b1, straps[3:0]}));
    if (w) check(33'(bus_address), 33'(straps));
    repeat (8) @(posedge clk_sys);
  endtask : do_reset
  initial begin
    void'($urandom(9));
    do_reset(1'b1);
    ctl(16'h001f);
    ad(OP_WRITE, 16'h0170);
    ad(OP_WRITE, 16'h0171);
    ad(OP_READ, 16'h0000);
    for (int f = 1; f < 4; f++) begin
      ctl({2'(f), 14'h001f});
      ad(OP_WRITE, 16'($urandom));
      repeat (2) ad(OP_READ, 16'h0000);
      ctl(16'h001f);
      ad(OP_READ, 16'h0000);
    end
    ctl(16'h401f);
    ad(OP_READ, 16'h0000);
    ctl(16'h001f);
    ad(OP_WRITE, 16'h000e);
    ctl(16'h801f);
    ad(OP_WRITE, 16'h1234);
    ad(OP_READ, 16'h0000);
    ctl(16'h401e);
    ad(OP_WRITE, 16'h4321);
    ad(OP_READ, 16'h0000);
    frame(2'b00, 5'h02, 16'h0000, 1'b1);
    frame(2'b11, 5'h02, 16'h0000, 1'b1);
    rand_frames(40);
    $display("test wide address done");
    do_reset(1'b0);
    frame(OP_WRITE, 5'h03, 16'h5aa5, 1'b0);
    frame(OP_READ, 5'h03, 16'h0000, 1'b1);
    rand_frames(20);
    $display("test narrow address done");
    check(33'(exp_wr.size()), 33'h0_0000_0000);
    conclude();
  end
endmodule : tb
